// ==== include/cdm_pkg.sv ====
package cdm_pkg;

    // register offsets of the control port
    localparam logic [3:0] MODULE_CTRL_OFS = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFS  = 4'h1;
    localparam logic [3:0] IRQ_ENABLE_OFS  = 4'h2;
    localparam logic [3:0] LAST_ERROR_OFS  = 4'h3;
    localparam logic [3:0] STAMP_CTRL_OFS  = 4'h4;
    localparam logic [3:0] STATUS_OFS      = 4'h5;

    // module_ctrl_reg fields
    localparam int MODE_LSB      = 0;
    localparam int MODE_W        = 3;
    localparam int ARB_RETRY_POS = 3;
    localparam int VALID_POS     = 4;

    // irq_status_reg fields
    localparam int TX_DONE_POS   = 0;
    localparam int PROTO_ERR_POS = 3;
    localparam int ARB_LOSS_POS  = 4;

    // stamp_ctrl_reg fields
    localparam int STAMP_EN_POS   = 0;
    localparam int STAMP_SEL_POS  = 1;
    localparam int STAMP_LOCK_POS = 2;

    // status register fields
    localparam int TX_PEND_POS = 0;
    localparam int BUS_OFF_POS = 1;
    localparam int SLEEP_POS   = 2;
    localparam int STAMP_OUT_POS = 3;

    localparam logic [7:0] TEC_BUS_OFF = 8'hFF;
    localparam logic [2:0] LEC_RESET   = 3'h0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;

    typedef enum logic [2:0] {
        CDM_INIT,
        CDM_NORMAL,
        CDM_NORMAL_ABT,
        CDM_RX_ONLY,
        CDM_SINGLE_SHOT,
        CDM_SELF_TEST
    } cdm_mode_t;

    // events reported by the protocol engine
    typedef struct packed {
        logic       sof;
        logic       eof_last;
        logic       data_frame;
        logic       rx_ok;
        logic       store_start;
        logic [3:0] store_buf;
        logic       tx_ok;
        logic       arb_lost;
        logic       error;
        logic [2:0] error_code;
    } cdm_evt_t;

    // bus actions the engine wants to take
    typedef struct packed {
        logic tx_bit_dominant;
        logic ack_drive;
        logic err_flag_drive;
        logic overload_drive;
    } cdm_drive_t;

endpackage : cdm_pkg

// ==== sim/cdm_bus_node.sv ====
`timescale 1ns/10ps
module cdm_bus_node
#(
    parameter int BIT_LEN = 4
)
(
    input  wire logic clk,    // clock
    input  wire logic rst,    // reset
    input  wire logic kick,   // send one dominant bit
    input  wire logic tx_pin, // device tx pin
    output logic      rx_pin  // bus level
);
    int unsigned dom_cnt;
    always_ff @(posedge clk)
    begin
        if (rst)
            dom_cnt <= 0;
        else if (kick)
            dom_cnt <= BIT_LEN;
        else if (dom_cnt != 0)
            dom_cnt <= dom_cnt - 1;
    end
    // wired-and bus, pull-up keeps idle recessive
    assign rx_pin = tx_pin && dom_cnt == 0;
endmodule : cdm_bus_node

// ==== sim/cdm_top_monitor.sv ====
`timescale 1ns/10ps
module cdm_top_monitor
(
    input wire logic               MCLK,       // clock
    input wire logic               RST,        // reset
    input wire logic [3:0]         ADDR,       // address
    input wire logic [7:0]         WDATA,      // write data
    input wire logic               WR,         // write strobe
    input wire cdm_pkg::cdm_evt_t   EVT,        // events
    input wire cdm_pkg::cdm_drive_t DRV,        // drive wishes
    input wire logic               SLEEP_REQ,  // sleep
    input wire logic               BUS_RX_PIN, // rx pin
    input wire logic               BUS_TX_PIN, // tx pin
    input wire logic               RX_BIT,     // rx bit
    input wire logic               TX_START,   // tx start
    input wire logic               ACK_SENT,   // ack
    input wire logic               IRQ_TX,     // irq
    input wire logic               STAMP_OUT,  // stamp
    input wire logic               WAKE        // wake
);
    import cdm_pkg::*;
    logic [2:0] mode_reg;
    logic       ien_reg;
    logic       sen_reg;
    logic       sel_reg;
    logic       lck_reg;
    logic       slp_reg;
    logic       rxp_reg;
    wire rxo = mode_reg == 3'h3;
    wire stm = mode_reg == 3'h5;
    wire act = mode_reg != 3'h0 && !slp_reg;
    wire sev = act && sen_reg && EVT.data_frame && (sel_reg ? EVT.eof_last : EVT.sof);
    // shadow of software settings
    always_ff @(posedge MCLK)
    begin
        if (RST)
            {mode_reg, ien_reg, sen_reg, sel_reg, lck_reg} <= 7'h00;
        else if (WR && ADDR == MODULE_CTRL_OFS)
            mode_reg <= (WDATA[2:0] > 3'h5) ? 3'h0 : WDATA[2:0];
        else if (WR && ADDR == IRQ_ENABLE_OFS)
            ien_reg <= WDATA[0];
        else if (WR && ADDR == STAMP_CTRL_OFS)
            {lck_reg, sel_reg, sen_reg} <= WDATA[2:0];
    end
    // sleep shadow leaves sleep on the same edge as the device
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            slp_reg <= 1'b0;
            rxp_reg <= 1'b1;
        end
        else
        begin
            rxp_reg <= BUS_RX_PIN;
            if (slp_reg && rxp_reg && !BUS_RX_PIN)
                slp_reg <= 1'b0;
            else if (SLEEP_REQ && mode_reg != 3'h0)
                slp_reg <= 1'b1;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_rxo_pin_idle: assert property (rxo && $past(rxo) |-> BUS_TX_PIN)
        else $error("tx pin driven in receive-only");
    chk_rxo_no_start: assert property (rxo && $past(rxo) |-> !TX_START)
        else $error("frame started in receive-only");
    chk_st_pin_idle: assert property (stm && $past(stm) |-> BUS_TX_PIN)
        else $error("tx pin driven in self-test");
    chk_st_loop_back: assert property (stm && $past(stm) && !slp_reg && !$past(slp_reg)
        |-> RX_BIT == !$past(DRV.tx_bit_dominant))
        else $error("loopback bit wrong");
    chk_irq_cause: assert property (IRQ_TX |-> $past(EVT.tx_ok && ien_reg && act && !rxo))
        else $error("irq without enabled tx done");
    chk_irq_fires: assert property (EVT.tx_ok && ien_reg && act && !rxo |=> IRQ_TX)
        else $error("irq missing on tx done");
    chk_ack_inside: assert property (EVT.rx_ok && act |=> ACK_SENT)
        else $error("ack not counted");
    chk_stamp_cause: assert property ($changed(STAMP_OUT) |-> $past(sev, 2))
        else $error("stamp toggled without event");
    chk_stamp_toggle: assert property (sev && !lck_reg |-> ##2 $changed(STAMP_OUT))
        else $error("stamp missed event");
    chk_wake_fall: assert property (slp_reg && $fell(BUS_RX_PIN) |-> ##[1:3] WAKE)
        else $error("no wake on falling rx");
endmodule : cdm_top_monitor
bind cdm_top cdm_top_monitor u_mon (.MCLK, .RST, .ADDR, .WDATA, .WR, .EVT, .DRV, .SLEEP_REQ,
    .BUS_RX_PIN, .BUS_TX_PIN, .RX_BIT, .TX_START, .ACK_SENT, .IRQ_TX, .STAMP_OUT, .WAKE);

// ==== sim/cdm_top_tb.sv ====
`timescale 1ns/10ps
module cdm_top_tb;
    import cdm_pkg::*;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, txreq = 0, slp = 0, kick = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, q;
    cdm_evt_t   evt = '0;
    cdm_drive_t drv = '0;
    logic rxp, txp, rx_bit, tx_start, tx_retry, ack_sent, irq_tx, stamp_out, wake;
    int bad_count = 0, samples_checked = 0, cyc = 0, n_retry = 0, n_irq = 0, n_wake = 0;
    logic stamp_q = 1'b0;
    int n_cap = 0;
    logic [19:0] rows [10] = '{20'h00B0B, 20'h01C0C, 20'h00700, 20'h20101, 20'h20000,
        20'h40606, 20'h40000, 20'h50F00, 20'h9FF00, 20'h11900};
    cdm_top DUT (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EVT(evt), .DRV(drv), .TX_REQ_SET(txreq), .SLEEP_REQ(slp),
        .BUS_RX_PIN(rxp), .BUS_TX_PIN(txp), .RX_BIT(rx_bit), .TX_START(tx_start),
        .TX_RETRY(tx_retry), .ACK_SENT(ack_sent), .IRQ_TX(irq_tx), .STAMP_OUT(stamp_out),
        .WAKE(wake));
    cdm_bus_node #(.BIT_LEN(4)) u_node (.clk(mclk), .rst(rst), .kick(kick), .tx_pin(txp),
        .rx_pin(rxp));
    always #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        n_retry += int'(tx_retry);
        n_irq += int'(irq_tx);
        n_wake += int'(wake);
        // capture timer model: one capture per trigger edge, either way
        if (!rst)
            n_cap += int'(stamp_out !== stamp_q);
        stamp_q = stamp_out;
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task ck(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s", $time, m);
            bad_count++;
        end
    endtask : ck
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        ck(rdata, e, m);
    endtask : rd_chk
    task ev(input cdm_evt_t e);
        #1;
        {n_retry, n_irq} = '0;
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
        repeat (3) @(posedge mclk);
        #1;
    endtask : ev
    task tq;
        @(posedge mclk);
        txreq <= 1'b1;
        @(posedge mclk);
        txreq <= 1'b0;
    endtask : tq
    task stamp_step(input logic [7:0] c, input logic eof, input logic exp);
        wr_reg(4'h4, c);
        ev('{sof:!eof, eof_last:eof, data_frame:1'b1, default:'0});
        ck(8'(stamp_out), 8'(exp), "stamp level");
    endtask : stamp_step
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rd_chk(i[3:0], 8'h00, "reset value");
        ck(8'(txp), 8'h01, "tx pin idle");
        for (int i = 0; i < 10; i++)
        begin
            wr_reg(rows[i][19:16], rows[i][15:8]);
            rd_chk(rows[i][19:16], rows[i][7:0], "register row");
        end
        $display("registers done");
        ev('{rx_ok:1'b1, default:'0});
        rd_chk(4'h0, 8'h00, "valid in init");
        wr_reg(4'h0, 8'h01);
        ev('{rx_ok:1'b1, default:'0});
        rd_chk(4'h0, 8'h11, "valid normal");
        wr_reg(4'h0, 8'h03);
        ev('{rx_ok:1'b1, default:'0});
        rd_chk(4'h0, 8'h13, "valid rx-only");
        drv <= '1;
        tq();
        repeat (32) ev('{error:1'b1, error_code:3'h1, default:'0});
        ck(8'(n_retry), 8'h00, "retry in rx-only");
        drv <= '0;
        rd_chk(4'h5, 8'h01, "rx-only pending, no bus-off");
        wr_reg(4'h0, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        ck(8'(tx_start), 8'h01, "pending starts");
        repeat (32) ev('{error:1'b1, error_code:3'h1, default:'0});
        rd_chk(4'h5, 8'h03, "bus-off in normal");
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h1, 8'h19);
        $display("rx-only done");
        ev('{arb_lost:1'b1, default:'0});
        ck(8'(n_retry), 8'h00, "no retry");
        rd_chk(4'h5, 8'h00, "flag cleared");
        rd_chk(4'h1, 8'h10, "arb status");
        wr_reg(4'h0, 8'h0C);
        wr_reg(4'h1, 8'h19);
        tq();
        ev('{arb_lost:1'b1, default:'0});
        ck(8'(n_retry), 8'h01, "retry on arb");
        ev('{error:1'b1, error_code:3'h5, default:'0});
        ck(8'(n_retry), 8'h00, "retry on error");
        rd_chk(4'h5, 8'h00, "flag cleared");
        rd_chk(4'h1, 8'h18, "error status");
        rd_chk(4'h3, 8'h05, "error code");
        wr_reg(4'h2, 8'h01);
        tq();
        ev('{tx_ok:1'b1, default:'0});
        ck(8'(n_irq), 8'h01, "irq on done");
        rd_chk(4'h1, 8'h19, "done status");
        wr_reg(4'h2, 8'h00);
        tq();
        ev('{tx_ok:1'b1, default:'0});
        ck(8'(n_irq), 8'h00, "irq masked");
        wr_reg(4'h0, 8'h01);
        tq();
        ev('{arb_lost:1'b1, default:'0});
        ck(8'(n_retry), 8'h01, "normal retry");
        $display("single-shot done");
        stamp_step(8'h01, 1'b0, 1'b1);
        stamp_step(8'h01, 1'b1, 1'b1);
        stamp_step(8'h03, 1'b1, 1'b0);
        stamp_step(8'h03, 1'b0, 1'b0);
        stamp_step(8'h02, 1'b1, 1'b0);
        stamp_step(8'h05, 1'b0, 1'b1);
        ev('{store_start:1'b1, store_buf:4'h1, data_frame:1'b1, default:'0});
        rd_chk(4'h4, 8'h05, "lock other buffer");
        ev('{store_start:1'b1, default:'0});
        rd_chk(4'h4, 8'h05, "lock remote");
        ev('{store_start:1'b1, data_frame:1'b1, default:'0});
        rd_chk(4'h4, 8'h04, "lock clears");
        ev('{sof:1'b1, data_frame:1'b1, default:'0});
        ck(8'(stamp_out), 8'h01, "frozen");
        wr_reg(4'h4, 8'h01);
        ev('{store_start:1'b1, data_frame:1'b1, default:'0});
        rd_chk(4'h4, 8'h01, "no lock");
        ck(8'(n_cap), 8'h03, "capture edges");
        $display("stamp done");
        drv <= '{tx_bit_dominant:1'b1, default:'0};
        repeat (2) @(posedge mclk);
        #1;
        ck(8'(txp), 8'h00, "pin dominant normal");
        wr_reg(4'h0, 8'h05);
        repeat (3) @(posedge mclk);
        #1;
        ck(8'(txp), 8'h01, "pin recessive self-test");
        slp <= 1'b1;
        @(posedge mclk);
        slp <= 1'b0;
        #1;
        n_wake = 0;
        @(posedge mclk);
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        ck(8'(n_wake), 8'h01, "wake");
        $display("self-test done");
        finish_test();
    end
endmodule : cdm_top_tb

// ==== src/cdm_stamp.sv ====
`timescale 1ns/10ps
module cdm_stamp
(
    input  wire logic     clk,          // clock
    input  wire logic     rst,          // sync reset
    input  wire cdm_pkg::cdm_evt_t evt, // engine events
    input  wire logic     stamp_sel,    // source select
    input  wire logic     stamp_lock,   // lock bit
    input  wire logic     stamp_en,     // enable bit
    output logic          lock_clear,   // clear enable request
    output logic          stamp_out     // toggling trigger
);
    import cdm_pkg::*;

    logic hit;

    // selected event during a data frame
    always_comb
    begin
        hit = evt.data_frame && (stamp_sel ? evt.eof_last : evt.sof);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            stamp_out <= 1'b0;
        else if (hit && stamp_en)
            stamp_out <= ~stamp_out;
    end

    // only data frames into buffer 0 freeze the stamp
    always_comb
    begin
        lock_clear = stamp_lock && evt.store_start && evt.data_frame
                     && (evt.store_buf == 4'h0);
    end
endmodule : cdm_stamp

// ==== src/cdm_top.sv ====
// Summary of operation
// - receive-only sends no frames; pending transmit requests stay pending.
// - receive-only holds transmit pin recessive, even on errors.
// - receive-only never changes transmit error counter, so no bus-off.
// - receive-only drives no acknowledge or overload; ack counts as sent.
// - valid flag set on every error-free acknowledged reception.
// - single-shot, retry bit 0: no retransmit after arbitration loss or error.
// - single-shot, retry bit 1: retransmit after arbitration loss, not error.
// - single-shot clears request flag on success or error, and on arbitration loss when retry bit is 0.
// - arbitration loss and error get own status bits; 3-bit error code kept.
// - success sets transmit-done bit; interrupt only if its enable is set.
// - retry bit matters only in single-shot mode.
// - self-test loops transmit to receiver and holds transmit pin recessive.
// - sleep entered from self-test still wakes on receive falling edge.
// - bus actions gated by mode per the mode table.
// - trigger output toggles on selected event in data frame reception.
// - source select 0 picks start of frame, 1 end of frame.
// - trigger toggles only while enable bit is 1.
// - lock bit 0: toggling continues, no auto disable.
// - lock bit 1: enable cleared when storing into buffer 0 begins.
// - no lock disable on remote frames or other buffers.
`timescale 1ns/10ps
module cdm_top
(
    input  wire logic        MCLK,        // 20 MHz clock
    input  wire logic        RST,         // sync reset, high
    input  wire logic [3:0]  ADDR,        // register address
    input  wire logic [7:0]  WDATA,       // write data
    input  wire logic        WR,          // write strobe
    input  wire logic        RD,          // read strobe
    output logic      [7:0]  RDATA,       // read data, next cycle
    input  wire cdm_pkg::cdm_evt_t   EVT, // protocol engine events
    input  wire cdm_pkg::cdm_drive_t DRV, // engine drive wishes
    input  wire logic        TX_REQ_SET,  // software sets a tx request
    input  wire logic        SLEEP_REQ,   // enter sleep
    input  wire logic        BUS_RX_PIN,  // receive pin
    output logic             BUS_TX_PIN,  // transmit pin, 1 recessive
    output logic             RX_BIT,      // bit seen by receiver
    output logic             TX_START,    // frame start granted
    output logic             TX_RETRY,    // retransmit pending frame
    output logic             ACK_SENT,    // ack counted internally
    output logic             IRQ_TX,      // transmit done interrupt
    output logic             STAMP_OUT,   // stamp trigger
    output logic             WAKE         // wake pulse from sleep
);
    import cdm_pkg::*;

    cdm_mode_t  mode_reg;
    logic       arb_retry_reg;
    logic       valid_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_enable_reg;
    logic [2:0] last_error_reg;
    logic       stamp_en_reg;
    logic       stamp_sel_reg;
    logic       stamp_lock_reg;
    logic       tx_request_flag;
    logic [7:0] tx_error_counter;
    logic       sleep_reg;
    logic       rx_prev_reg;
    logic       lock_clear;
    logic       stamp_raw;

    logic       rx_only;
    logic       self_test;
    logic       single;
    logic       active;
    logic       wr_ctrl;
    logic       wr_irq;
    logic       wr_stamp;
    logic       rx_bit;
    logic       retry_arb;
    logic       retry_err;

    function automatic logic [7:0] mode_bits(input cdm_mode_t m);
        mode_bits = {5'h00, m};
    endfunction : mode_bits

    function automatic cdm_mode_t mode_of(input logic [2:0] v);
        if (v > 3'(CDM_SELF_TEST))
            mode_of = CDM_INIT;
        else
            mode_of = cdm_mode_t'(v);
    endfunction : mode_of

    always_comb
    begin
        rx_only   = (mode_reg == CDM_RX_ONLY);
        self_test = (mode_reg == CDM_SELF_TEST);
        single    = (mode_reg == CDM_SINGLE_SHOT);
        active    = (mode_reg != CDM_INIT) && !sleep_reg;
        wr_ctrl   = WR && (ADDR == MODULE_CTRL_OFS);
        wr_irq    = WR && (ADDR == IRQ_STATUS_OFS);
        wr_stamp  = WR && (ADDR == STAMP_CTRL_OFS);
        // loopback in self-test, else the bus pin
        rx_bit    = self_test ? ~DRV.tx_bit_dominant : BUS_RX_PIN;
        // retry bit only counts in single-shot
        retry_arb = single ? arb_retry_reg : 1'b1;
        retry_err = !single;
    end

    // mode and retry bit
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            mode_reg      <= CDM_INIT;
            arb_retry_reg <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            mode_reg      <= mode_of(WDATA[MODE_LSB +: MODE_W]);
            arb_retry_reg <= WDATA[ARB_RETRY_POS];
        end
    end

    // valid flag, software clears by writing 0; set wins
    always_ff @(posedge MCLK)
    begin
        if (RST)
            valid_reg <= 1'b0;
        else if (active && EVT.rx_ok)
            valid_reg <= 1'b1;
        else if (wr_ctrl && !WDATA[VALID_POS])
            valid_reg <= 1'b0;
    end

    // status bits: write 1 to clear, set wins
    always_ff @(posedge MCLK)
    begin
        if (RST)
            irq_status_reg <= CTRL_RESET;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (wr_irq && WDATA[i])
                    irq_status_reg[i] <= 1'b0;
            end
            if (active && !rx_only && EVT.tx_ok)
                irq_status_reg[TX_DONE_POS] <= 1'b1;
            if (active && !rx_only && EVT.error)
                irq_status_reg[PROTO_ERR_POS] <= 1'b1;
            if (active && !rx_only && EVT.arb_lost)
                irq_status_reg[ARB_LOSS_POS] <= 1'b1;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            irq_enable_reg <= CTRL_RESET;
        else if (WR && (ADDR == IRQ_ENABLE_OFS))
            irq_enable_reg <= WDATA;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            last_error_reg <= LEC_RESET;
        else if (active && EVT.error)
            last_error_reg <= EVT.error_code;
        else if (WR && (ADDR == LAST_ERROR_OFS))
            last_error_reg <= LEC_RESET;
    end

    // stamp control; hardware lock clear wins over software write
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            stamp_en_reg   <= 1'b0;
            stamp_sel_reg  <= 1'b0;
            stamp_lock_reg <= 1'b0;
        end
        else
        begin
            if (wr_stamp)
            begin
                stamp_sel_reg  <= WDATA[STAMP_SEL_POS];
                stamp_lock_reg <= WDATA[STAMP_LOCK_POS];
            end
            if (lock_clear && active)
                stamp_en_reg <= 1'b0;
            else if (wr_stamp)
                stamp_en_reg <= WDATA[STAMP_EN_POS];
        end
    end

    // transmit request flag of the transmit buffer
    always_ff @(posedge MCLK)
    begin
        if (RST)
            tx_request_flag <= 1'b0;
        else if (TX_REQ_SET)
            tx_request_flag <= 1'b1;
        else if (!active || rx_only)
            tx_request_flag <= tx_request_flag;
        else if (EVT.tx_ok)
            tx_request_flag <= 1'b0;
        else if (EVT.arb_lost && !retry_arb)
            tx_request_flag <= 1'b0;
        else if (EVT.error && !retry_err)
            tx_request_flag <= 1'b0;
    end

    // transmit error counter, frozen in receive-only and init
    always_ff @(posedge MCLK)
    begin
        if (RST)
            tx_error_counter <= 8'h00;
        else if (wr_ctrl && mode_of(WDATA[MODE_LSB +: MODE_W]) == CDM_INIT)
            tx_error_counter <= 8'h00;
        else if (active && !rx_only)
        begin
            if (EVT.error && tx_error_counter < TEC_BUS_OFF - 8'h08)
                tx_error_counter <= tx_error_counter + 8'h08;
            else if (EVT.error)
                tx_error_counter <= TEC_BUS_OFF;
            else if (EVT.tx_ok && tx_error_counter != 8'h00)
                tx_error_counter <= tx_error_counter - 8'h01;
        end
    end

    // sleep in any mode but init, wake on receive falling edge
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            sleep_reg   <= 1'b0;
            rx_prev_reg <= 1'b1;
            WAKE        <= 1'b0;
        end
        else
        begin
            rx_prev_reg <= BUS_RX_PIN;
            WAKE        <= 1'b0;
            if (sleep_reg && rx_prev_reg && !BUS_RX_PIN)
            begin
                sleep_reg <= 1'b0;
                WAKE      <= 1'b1;
            end
            else if (SLEEP_REQ && mode_reg != CDM_INIT)
                sleep_reg <= 1'b1;
        end
    end

    // pin and engine grants
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            BUS_TX_PIN <= 1'b1;
            RX_BIT     <= 1'b1;
            TX_START   <= 1'b0;
            TX_RETRY   <= 1'b0;
            ACK_SENT   <= 1'b0;
            IRQ_TX     <= 1'b0;
        end
        else
        begin
            // only normal, normal-abort and single-shot modes reach the pin
            if (active && !rx_only && !self_test)
                BUS_TX_PIN <= ~(DRV.tx_bit_dominant | DRV.ack_drive
                               | DRV.err_flag_drive | DRV.overload_drive);
            else
                BUS_TX_PIN <= 1'b1;
            RX_BIT   <= rx_bit;
            TX_START <= active && !rx_only && tx_request_flag;
            TX_RETRY <= active && !rx_only && tx_request_flag
                        && ((EVT.arb_lost && retry_arb) || (EVT.error && retry_err));
            ACK_SENT <= active && EVT.rx_ok;
            IRQ_TX   <= active && !rx_only && EVT.tx_ok
                        && irq_enable_reg[TX_DONE_POS];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            STAMP_OUT <= 1'b0;
        else
            STAMP_OUT <= stamp_raw;
    end

    // read data one cycle after the strobe
    always_ff @(posedge MCLK)
    begin
        if (RST)
            RDATA <= 8'h00;
        else if (!RD)
            RDATA <= 8'h00;
        else if (ADDR == MODULE_CTRL_OFS)
            RDATA <= mode_bits(mode_reg) | {3'h0, valid_reg, arb_retry_reg, 3'h0};
        else if (ADDR == IRQ_STATUS_OFS)
            RDATA <= irq_status_reg;
        else if (ADDR == IRQ_ENABLE_OFS)
            RDATA <= irq_enable_reg;
        else if (ADDR == LAST_ERROR_OFS)
            RDATA <= {5'h00, last_error_reg};
        else if (ADDR == STAMP_CTRL_OFS)
            RDATA <= {5'h00, stamp_lock_reg, stamp_sel_reg, stamp_en_reg};
        else if (ADDR == STATUS_OFS)
            RDATA <= {4'h0, stamp_raw, sleep_reg,
                      tx_error_counter == TEC_BUS_OFF, tx_request_flag};
        else
            RDATA <= 8'h00;
    end

    // stamp unit sees events only when the mode lets reception happen
    cdm_evt_t evt_gated;
    always_comb
    begin
        evt_gated = active ? EVT : '0;
    end

    cdm_stamp u_stamp (
        .clk        (MCLK),
        .rst        (RST),
        .evt        (evt_gated),
        .stamp_sel  (stamp_sel_reg),
        .stamp_lock (stamp_lock_reg),
        .stamp_en   (stamp_en_reg),
        .lock_clear (lock_clear),
        .stamp_out  (stamp_raw)
    );
endmodule : cdm_top
